// ===== rtl/rgp_pkg.sv
// Package: register map, field positions, reset values and opcode set
package rgp_pkg;
   // Register offsets
   localparam logic [7:0] RGP_SOFTWARE_RESET_OFS = 8'h0d;
   localparam logic [7:0] RGP_GENERAL_OUTPUT_CONTROL_OFS = 8'h0e;
   localparam logic [7:0] RGP_STATUS_INT_OFS = 8'h0c;
   localparam logic [7:0] RGP_PROG_FIRST_OFS = 8'h10;
   localparam logic [7:0] RGP_PROG_LAST_OFS = 8'h6f;
   // Reset values and magic
   localparam logic [7:0] RGP_RESET_MAGIC = 8'hff;
   localparam logic [7:0] RGP_GPO_RST = 8'h00;
   localparam logic [7:0] RGP_PROG_RST = 8'h00;
   localparam logic [7:0] RGP_SWRST_READ = 8'h00;
   // General output register fields
   localparam int RGP_ALERT_LEVEL_BIT = 0;
   localparam int RGP_SPARE_LEVEL_BIT = 1;
   localparam int RGP_OVERRIDE_BIT = 2;
   localparam logic [7:0] RGP_GPO_MASK = 8'h07;
   // Instruction word fields
   localparam int RGP_INS_TOP = 15;
   localparam int RGP_INS_PRESCALE_BIT = 14;
   localparam int RGP_INS_STEP_TIME_HI = 13;
   localparam int RGP_INS_STEP_TIME_LO = 9;
   localparam int RGP_INS_END_INT_BIT = 12;
   localparam int RGP_INS_END_RST_BIT = 11;
   // Decoded operations
   typedef enum logic [2:0] {
      RGP_OP_RAMP = 3'h0,
      RGP_OP_SET_PWM = 3'h1,
      RGP_OP_GO_START = 3'h2,
      RGP_OP_BRANCH = 3'h3,
      RGP_OP_END = 3'h4,
      RGP_OP_TRIGGER = 3'h5
   } rgp_op_t;
endpackage : rgp_pkg

// ===== rtl/rgp_insn_decode.sv
// Combinational decoder for one 16-bit program instruction word
`timescale 1ns/1ps
module rgp_insn_decode
   import rgp_pkg::*;
(
   input wire logic [15:0] insn_i, // Instruction word, MSB first byte
   output rgp_op_t op_o, // Decoded operation
   output logic prescale_o, // Ramp prescale select
   output logic [4:0] step_time_o, // Ramp step time
   output logic [8:0] increment_o, // Ramp sign and increment
   output logic [7:0] pwm_value_o, // Set PWM duty
   output logic [5:0] loop_count_o, // Branch loop count
   output logic [3:0] step_number_o, // Branch target step
   output logic end_int_o, // End requests interrupt
   output logic end_reset_o, // End requests reset
   output logic [5:0] wait_mask_o, // Trigger channels to wait on
   output logic [5:0] send_mask_o // Trigger channels to signal
);
   // Form matches, checked top-three-bit forms first, then zero word, then PWM prefix
   wire is_zero = (insn_i == 16'h0000);
   wire is_pwm = (insn_i[15:8] == 8'h40);
   wire [2:0] top3 = insn_i[15:13];
   assign op_o = top3 == 3'h7 ? RGP_OP_TRIGGER :
                 top3 == 3'h6 ? RGP_OP_END :
                 top3 == 3'h5 ? RGP_OP_BRANCH :
                 is_zero ? RGP_OP_GO_START :
                 is_pwm ? RGP_OP_SET_PWM :
                 RGP_OP_RAMP;
   // Field extraction is unconditional; op_o says which fields mean anything
   assign prescale_o = insn_i[RGP_INS_PRESCALE_BIT];
   assign step_time_o = insn_i[RGP_INS_STEP_TIME_HI:RGP_INS_STEP_TIME_LO];
   assign increment_o = insn_i[8:0];
   assign pwm_value_o = insn_i[7:0];
   assign loop_count_o = insn_i[12:7];
   assign step_number_o = insn_i[3:0];
   assign end_int_o = insn_i[RGP_INS_END_INT_BIT];
   assign end_reset_o = insn_i[RGP_INS_END_RST_BIT];
   assign wait_mask_o = insn_i[12:7];
   assign send_mask_o = insn_i[6:1];
endmodule : rgp_insn_decode

// ===== rtl/rgp_prog_mem.sv
// Program store: byte array with synchronous clear and word view
`timescale 1ns/1ps
module rgp_prog_mem
   import rgp_pkg::*;
#(
   parameter int DEPTH = 96 // Bytes, 10h..6fh
)(
   input wire logic clk_sys_i, // System clock
   input wire logic rstn_i, // Async reset, active low
   input wire logic clear_i, // Software reset, clears all bytes
   input wire logic we_i, // Byte write strobe
   input wire logic [6:0] addr_i, // Byte index
   input wire logic [7:0] wdata_i, // Write byte
   input wire logic [5:0] word_idx_i, // Instruction index
   output logic [7:0] rdata_o, // Byte at addr_i
   output logic [15:0] word_o // Instruction at word_idx_i
);
   logic [7:0] mem_q [DEPTH];
   // Clear costs a flop per bit, but every location must read zero
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= RGP_PROG_RST;
      end else if (clear_i) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= RGP_PROG_RST;
      end else if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
   end
   // Even byte is the high half of the word
   wire [6:0] hi_idx = {word_idx_i, 1'b0};
   wire [6:0] lo_idx = {word_idx_i, 1'b1};
   assign rdata_o = mem_q[addr_i];
   assign word_o = {mem_q[hi_idx], mem_q[lo_idx]};
endmodule : rgp_prog_mem

// ===== rtl/rgp_reset_gpo_program_store.sv
// Register bank: software reset, general output pins and program store
// How it works
// - Writing FFh to reset clears all registers, but a status flag pulsed in that same cycle is kept
// - Reset-value write gets no acknowledge
// - Override bit hands alert pin to output
// - Under override, bit 0 sets alert level
// - Bit 1 drives spare output pin level
// - Program bytes 10h-6Fh, zero after reset
// - Bit 15 clear otherwise decodes as ramp
// - Top bits 110 decode as end
// - Top bits 111 decode as trigger
// - Alert pin low-active, released on status read
`timescale 1ns/1ps
module rgp_reset_gpo_program_store
   import rgp_pkg::*;
#(
   parameter int PROG_BYTES = 96 // Program store depth in bytes
)(
   input wire logic clk_sys_i, // 40 MHz system clock
   input wire logic rstn_i, // Async reset, active low
   input wire logic reg_wr_i, // Register write strobe
   input wire logic reg_rd_i, // Register read strobe
   input wire logic [7:0] reg_addr_i, // Register address
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic [2:0] chan_int_i, // Engine end-of-program pulses
   input wire logic [5:0] insn_idx_i, // Instruction index to decode
   output logic [7:0] reg_rdata_o, // Read data, valid cycle after strobe
   output logic reg_ack_o, // Acknowledge of write or read
   output logic alert_pin_o, // Interrupt / general pin level
   output logic spare_output_level_o, // Spare output pin level
   output logic [15:0] insn_word_o, // Registered instruction word
   output rgp_op_t insn_op_o, // Registered decoded operation
   output logic [7:0] insn_arg_o, // Registered low argument byte
   output logic insn_end_int_o // Registered end interrupt flag
);
   // Address decode
   wire hit_swrst = (reg_addr_i == RGP_SOFTWARE_RESET_OFS);
   wire hit_gpo = (reg_addr_i == RGP_GENERAL_OUTPUT_CONTROL_OFS);
   wire hit_stat = (reg_addr_i == RGP_STATUS_INT_OFS);
   wire hit_prog = (reg_addr_i >= RGP_PROG_FIRST_OFS) && (reg_addr_i <= RGP_PROG_LAST_OFS);
   wire [7:0] prog_ofs = reg_addr_i - RGP_PROG_FIRST_OFS;
   wire [6:0] prog_idx = prog_ofs[6:0];
   wire sw_reset = reg_wr_i && hit_swrst && (reg_wdata_i == RGP_RESET_MAGIC);

   // General output register; only low three bits are stored
   logic [2:0] gpo_q;
   wire [2:0] gpo_d = reg_wdata_i[2:0] & RGP_GPO_MASK[2:0];
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gpo_q <= RGP_GPO_RST[2:0];
      end else if (sw_reset) begin
         gpo_q <= RGP_GPO_RST[2:0];
      end else if (reg_wr_i && hit_gpo) begin
         gpo_q <= gpo_d;
      end
   end

   // Sticky channel interrupt flags; a set in the read cycle survives
   logic [2:0] int_q;
   wire stat_read = reg_rd_i && hit_stat;
   wire [2:0] int_d = (stat_read ? 3'h0 : int_q) | chan_int_i;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         int_q <= 3'h0;
      end else if (sw_reset) begin
         int_q <= chan_int_i;
      end else begin
         int_q <= int_d;
      end
   end

   // Program store
   wire [7:0] prog_rdata;
   wire [15:0] prog_word;
   rgp_prog_mem #(.DEPTH(PROG_BYTES)) u_mem (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .clear_i(sw_reset),
      .we_i(reg_wr_i && hit_prog),
      .addr_i(prog_idx),
      .wdata_i(reg_wdata_i),
      .word_idx_i(insn_idx_i),
      .rdata_o(prog_rdata),
      .word_o(prog_word)
   );

   // Instruction decode of the selected word
   rgp_op_t dec_op;
   wire [7:0] dec_pwm;
   wire dec_int;
   rgp_insn_decode u_dec (
      .insn_i(prog_word),
      .op_o(dec_op),
      .prescale_o(),
      .step_time_o(),
      .increment_o(),
      .pwm_value_o(dec_pwm),
      .loop_count_o(),
      .step_number_o(),
      .end_int_o(dec_int),
      .end_reset_o(),
      .wait_mask_o(),
      .send_mask_o()
   );

   // Read mux; unmapped addresses and the reset register read zero
   wire [7:0] rd_mux = hit_gpo ? {5'h00, gpo_q} :
                       hit_stat ? {5'h00, int_q} :
                       hit_prog ? prog_rdata :
                       RGP_SWRST_READ;

   // Pin levels: alert is low while any flag pends, unless overridden
   wire alert_d = gpo_q[RGP_OVERRIDE_BIT] ? gpo_q[RGP_ALERT_LEVEL_BIT] :
                  ~|int_d;
   // The magic write is swallowed: no acknowledge so host sees a NAK
   wire ack_d = (reg_wr_i && !sw_reset) || reg_rd_i;

   // Registered outputs
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 8'h00;
         reg_ack_o <= 1'b0;
         alert_pin_o <= 1'b1;
         spare_output_level_o <= 1'b0;
         insn_word_o <= 16'h0000;
         insn_op_o <= RGP_OP_GO_START;
         insn_arg_o <= 8'h00;
         insn_end_int_o <= 1'b0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
         reg_ack_o <= ack_d;
         alert_pin_o <= alert_d;
         spare_output_level_o <= gpo_q[RGP_SPARE_LEVEL_BIT];
         insn_word_o <= prog_word;
         insn_op_o <= dec_op;
         insn_arg_o <= dec_pwm;
         insn_end_int_o <= dec_int;
      end
   end

   // Assertions
   property p_swrst_clears_gpo;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      sw_reset |=> gpo_q == 3'h0;
   endproperty
   a_swrst_clears_gpo: assert property (p_swrst_clears_gpo)
      else $error("gpo not cleared by software reset");

   property p_magic_no_ack;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      sw_reset |=> !reg_ack_o;
   endproperty
   a_magic_no_ack: assert property (p_magic_no_ack)
      else $error("magic reset write was acknowledged");

   property p_override_level;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      gpo_q[RGP_OVERRIDE_BIT] |=> alert_pin_o == $past(gpo_q[RGP_ALERT_LEVEL_BIT]);
   endproperty
   a_override_level: assert property (p_override_level)
      else $error("alert pin ignores override level");

   property p_spare_level;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      reg_wr_i && hit_gpo && !sw_reset ##2 1'b1 |-> spare_output_level_o == $past(reg_wdata_i[1], 2);
   endproperty
   a_spare_level: assert property (p_spare_level)
      else $error("spare pin does not follow written bit");

   property p_prog_readback;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      reg_wr_i && hit_prog ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i, 2)
         |=> reg_rdata_o == $past(reg_wdata_i, 3);
   endproperty
   a_prog_readback: assert property (p_prog_readback)
      else $error("program byte read back wrong");

   property p_alert_active;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      !gpo_q[RGP_OVERRIDE_BIT] && (int_q != 3'h0) && !stat_read |=> !alert_pin_o;
   endproperty
   a_alert_active: assert property (p_alert_active)
      else $error("alert pin not low with pending flag");

   property p_gpo_high_zero;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      reg_rd_i && hit_gpo |=> reg_rdata_o[7:3] == 5'h00;
   endproperty
   a_gpo_high_zero: assert property (p_gpo_high_zero)
      else $error("general output upper bits not zero");

   property p_swrst_reads_zero;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      reg_rd_i && hit_swrst |=> reg_rdata_o == 8'h00;
   endproperty
   a_swrst_reads_zero: assert property (p_swrst_reads_zero)
      else $error("reset register read nonzero");

   property p_zero_go_start;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      prog_word == 16'h0000 |=> insn_op_o == RGP_OP_GO_START;
   endproperty
   a_zero_go_start: assert property (p_zero_go_start)
      else $error("zero word not decoded as go to start");

   property p_top_branch;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      prog_word[15:13] == 3'h5 |=> insn_op_o == RGP_OP_BRANCH;
   endproperty
   a_top_branch: assert property (p_top_branch)
      else $error("branch form misdecoded");

   // Override with a low level must pull the pin even with no flag pending
   property p_override_takes_pin;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      gpo_q[RGP_OVERRIDE_BIT] && !gpo_q[RGP_ALERT_LEVEL_BIT] |=> !alert_pin_o;
   endproperty
   a_override_takes_pin: assert property (p_override_takes_pin)
      else $error("override did not take the alert pin");

   property p_ramp_decode;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      !prog_word[15] && prog_word != 16'h0000 && prog_word[15:8] != 8'h40
         |=> insn_op_o == RGP_OP_RAMP;
   endproperty
   a_ramp_decode: assert property (p_ramp_decode)
      else $error("ramp form misdecoded");

   property p_set_pwm_decode;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      prog_word[15:8] == 8'h40
         |=> insn_op_o == RGP_OP_SET_PWM && insn_arg_o == $past(prog_word[7:0]);
   endproperty
   a_set_pwm_decode: assert property (p_set_pwm_decode)
      else $error("set pwm form misdecoded");

   property p_end_decode;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      prog_word[15:13] == 3'h6
         |=> insn_op_o == RGP_OP_END && insn_end_int_o == $past(prog_word[12]);
   endproperty
   a_end_decode: assert property (p_end_decode)
      else $error("end form misdecoded");

   property p_trigger_decode;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      prog_word[15:13] == 3'h7 |=> insn_op_o == RGP_OP_TRIGGER;
   endproperty
   a_trigger_decode: assert property (p_trigger_decode)
      else $error("trigger form misdecoded");

   // Status read with no new pulse releases the pin
   property p_stat_release;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      stat_read && chan_int_i == 3'h0 && !gpo_q[RGP_OVERRIDE_BIT] |=> alert_pin_o;
   endproperty
   a_stat_release: assert property (p_stat_release)
      else $error("alert pin not released after status read");

   property p_stat_clears;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      stat_read && chan_int_i == 3'h0 |=> int_q == 3'h0;
   endproperty
   a_stat_clears: assert property (p_stat_clears)
      else $error("status read left flags set");

   property p_swrst_clears_flags;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      sw_reset && chan_int_i == 3'h0 |=> int_q == 3'h0;
   endproperty
   a_swrst_clears_flags: assert property (p_swrst_clears_flags)
      else $error("flags not cleared by software reset");

   // The word at insn_idx_i reads zero after the clear
   property p_swrst_clears_prog;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      sw_reset |=> prog_word == 16'h0000;
   endproperty
   a_swrst_clears_prog: assert property (p_swrst_clears_prog)
      else $error("program store not cleared by software reset");

   // Spare pin lags the register by one cycle
   property p_swrst_spare_low;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      sw_reset ##1 1'b1 |=> !spare_output_level_o;
   endproperty
   a_swrst_spare_low: assert property (p_swrst_spare_low)
      else $error("spare pin not low after software reset");

   property p_plain_ack;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (reg_wr_i && !sw_reset) || reg_rd_i |=> reg_ack_o;
   endproperty
   a_plain_ack: assert property (p_plain_ack)
      else $error("ordinary access not acknowledged");

   // Covers
   c_swrst: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) sw_reset);
   c_override: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      gpo_q[RGP_OVERRIDE_BIT] ##1 !alert_pin_o);
   c_stat_clear: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      stat_read && int_q != 3'h0);
   c_trigger: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      insn_op_o == RGP_OP_TRIGGER);
   c_end_int: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
      insn_op_o == RGP_OP_END && insn_end_int_o);
endmodule : rgp_reset_gpo_program_store

// ===== dv/rgp_host_model.sv
// Host model: byte writes and reads over the register strobes
`timescale 1ns/1ps
module rgp_host_model (
   input wire logic clk_sys_i, // System clock
   input wire logic reg_ack_i, // Acknowledge from the bank
   input wire logic [7:0] reg_rdata_i, // Read data from the bank
   output logic reg_wr_o, // Write strobe
   output logic reg_rd_o, // Read strobe
   output logic [7:0] reg_addr_o, // Register address
   output logic [7:0] reg_wdata_o // Write data
);
   // Idle strobes from time zero
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end

   // Missing acknowledge is handed back, never treated as a failure here
   task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data, output logic ack);
      @(negedge clk_sys_i);
      reg_wr_o = 1'b1;
      reg_addr_o = addr;
      reg_wdata_o = data;
      @(negedge clk_sys_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~data; // Stale data must not look valid
      ack = reg_ack_i;
   endtask : wr_byte

   // Read data and acknowledge stand one cycle after the strobe
   task automatic rd_byte(input logic [7:0] addr, output logic [7:0] data, output logic ack);
      @(negedge clk_sys_i);
      reg_rd_o = 1'b1;
      reg_addr_o = addr;
      @(negedge clk_sys_i);
      reg_rd_o = 1'b0;
      data = reg_rdata_i;
      ack = reg_ack_i;
   endtask : rd_byte

   // Instruction stored high byte at the even address first
   task automatic wr_word(input logic [5:0] idx, input logic [15:0] word);
      logic [7:0] addr;
      logic ack;
      addr = 8'h10 + {1'b0, idx, 1'b0};
      wr_byte(addr, word[15:8], ack);
      wr_byte(addr + 8'h01, word[7:0], ack);
   endtask : wr_word
endmodule : rgp_host_model

// ===== dv/tb.sv
// Testbench: register accesses, pins, software reset and decode
`timescale 1ns/1ps
module tb;
   import rgp_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [2:0] chan_int_i = 3'h0;
   logic [5:0] insn_idx_i = 6'h00;
   logic reg_wr, reg_rd, reg_ack, alert_pin, spare_pin, end_int, ack;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, insn_arg, rd;
   logic [15:0] insn_word;
   rgp_op_t insn_op;
   int fail_count = 0;
   int samples_checked = 0;
   // Instruction table: slot, word, expected operation
   logic [5:0] ins_i [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h2f};
   logic [15:0] ins_w [8] = '{16'h0000, 16'h40a5, 16'h037f, 16'h4d00, 16'ha123, 16'hd000,
      16'hc800, 16'he0fe};
   rgp_op_t ins_op [8] = '{RGP_OP_GO_START, RGP_OP_SET_PWM, RGP_OP_RAMP, RGP_OP_RAMP,
      RGP_OP_BRANCH, RGP_OP_END, RGP_OP_END, RGP_OP_TRIGGER};

   always #12.5 clk_sys_i = ~clk_sys_i;

   rgp_reset_gpo_program_store #(.PROG_BYTES(96)) dut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .chan_int_i(chan_int_i),
      .insn_idx_i(insn_idx_i), .reg_rdata_o(reg_rdata), .reg_ack_o(reg_ack),
      .alert_pin_o(alert_pin), .spare_output_level_o(spare_pin), .insn_word_o(insn_word),
      .insn_op_o(insn_op), .insn_arg_o(insn_arg), .insn_end_int_o(end_int));

   rgp_host_model host (
      .clk_sys_i(clk_sys_i), .reg_ack_i(reg_ack), .reg_rdata_i(reg_rdata),
      .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // Registered pins need two edges to show a change
   task automatic settle;
      repeat (2) @(negedge clk_sys_i);
   endtask : settle

   // One end pulse from the engines on the given channels
   task automatic pulse(input logic [2:0] chans);
      @(negedge clk_sys_i);
      chan_int_i = chans;
      @(negedge clk_sys_i);
      chan_int_i = 3'h0;
   endtask : pulse

   // Bound on the whole run against a hung sequence
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      repeat (8) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      settle();
      check(alert_pin, 1'b1);
      check(spare_pin, 1'b0);
      host.rd_byte(RGP_SOFTWARE_RESET_OFS, rd, ack);
      check(rd, RGP_SWRST_READ);
      host.rd_byte(RGP_PROG_LAST_OFS, rd, ack);
      check(rd, RGP_PROG_RST);
      host.rd_byte(8'hf0, rd, ack);
      check({ack, rd}, 9'h100);
      // Unused bits dropped, override hands pin to level bit
      host.wr_byte(RGP_GENERAL_OUTPUT_CONTROL_OFS, 8'hff, ack);
      check(ack, 1'b1);
      settle();
      check(spare_pin, 1'b1);
      host.rd_byte(RGP_GENERAL_OUTPUT_CONTROL_OFS, rd, ack);
      check(rd, 8'h07);
      host.wr_byte(RGP_GENERAL_OUTPUT_CONTROL_OFS, 8'hfc, ack);
      settle();
      check(alert_pin, 1'b0);
      check(spare_pin, 1'b0);
      host.wr_byte(RGP_GENERAL_OUTPUT_CONTROL_OFS, 8'h02, ack);
      settle();
      check(alert_pin, 1'b1);
      check(spare_pin, 1'b1);
      // End pulses hold the pin low until the status read
      pulse(3'h5);
      settle();
      check(alert_pin, 1'b0);
      host.rd_byte(RGP_STATUS_INT_OFS, rd, ack);
      check(rd, 8'h05);
      settle();
      check(alert_pin, 1'b1);
      // Program store, both ends of the range
      for (int i = 0; i < 8; i++) begin
         host.wr_word(ins_i[i], ins_w[i]);
      end
      // Write then read of one spare slot, one idle cycle apart
      host.wr_byte(8'h30, 8'h5a, ack);
      host.rd_byte(8'h30, rd, ack);
      check(rd, 8'h5a);
      host.rd_byte(8'h15, rd, ack);
      check(rd, 8'h7f);
      host.rd_byte(8'h6e, rd, ack);
      check(rd, 8'he0);
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_sys_i);
         insn_idx_i = ins_i[i];
         settle();
         check(insn_word, ins_w[i]);
         check({13'h0, insn_op}, {13'h0, ins_op[i]});
         check({8'h00, insn_arg}, {8'h00, ins_w[i][7:0]});
         check(end_int, ins_w[i][12]);
      end
      // Non-magic value is ignored, magic clears everything unacknowledged
      pulse(3'h2);
      host.wr_byte(RGP_SOFTWARE_RESET_OFS, 8'h12, ack);
      check(ack, 1'b1);
      host.wr_byte(RGP_SOFTWARE_RESET_OFS, RGP_RESET_MAGIC, ack);
      check(ack, 1'b0);
      settle();
      check(alert_pin, 1'b1);
      check(spare_pin, 1'b0);
      check(insn_word, 16'h0000);
      host.rd_byte(RGP_GENERAL_OUTPUT_CONTROL_OFS, rd, ack);
      check(rd, RGP_GPO_RST);
      host.rd_byte(RGP_STATUS_INT_OFS, rd, ack);
      check(rd, 8'h00);
      host.rd_byte(8'h6e, rd, ack);
      check(rd, RGP_PROG_RST);
      tally_and_finish();
   end
endmodule : tb
